// *** core/flip_pkg.sv ***
package flip_pkg;

  // Register port request, one strobe at most per cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } flip_bus_t;

  // Request presented to the processor core
  typedef struct packed {
    logic req;
    logic [7:0] vector;
    logic [1:0] level;
  } flip_core_t;

  // Answers from the processor core
  typedef struct packed {
    logic ack;
    logic reti;
  } flip_core_ret_t;

  // Source index equals natural rank minus one
  typedef enum logic [3:0] {
    FLIP_SRC_EXT0 = 4'h0,
    FLIP_SRC_TMR0 = 4'h1,
    FLIP_SRC_EXT1 = 4'h2,
    FLIP_SRC_TMR1 = 4'h3,
    FLIP_SRC_PCA = 4'h4,
    FLIP_SRC_SER = 4'h5,
    FLIP_SRC_TMR2 = 4'h6,
    FLIP_SRC_CAN = 4'h7,
    FLIP_SRC_ADC = 4'h8,
    FLIP_SRC_CANSW = 4'h9
  } flip_src_t;

endpackage

// *** core/flip_prioritizer.sv ***
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "flip_regs.svh"

module flip_prioritizer (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire flip_pkg::flip_bus_t bus_in,
  output flip_pkg::flip_core_t core_out,
  input wire flip_pkg::flip_core_ret_t core_ret_in,
  output logic [7:0] rdata_out,
  output logic irq_out,
  input wire logic ext_request_zero_in,
  input wire logic ext_request_one_in,
  input wire logic timer_zero_overflow_in,
  input wire logic timer_one_overflow_in,
  input wire logic timer_two_overflow_in,
  input wire logic [1:0] serial_rx_tx_done_in,
  input wire logic counter_array_in,
  input wire logic [2:0] can_event_in,
  input wire logic adc_done_request_in,
  input wire logic can_sw_timer_in
);
  import flip_pkg::*;

  localparam int NSRC = `FLIP_NUM_SRC;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Two stages per pin; only the second stage feeds edge detection
  logic [1:0] ext_meta_q;
  logic [1:0] ext_meta_d;
  logic [1:0] ext_sync_q;
  logic [1:0] ext_sync_d;

  always_comb begin
    ext_meta_d = {ext_request_one_in, ext_request_zero_in};
    ext_sync_d = ext_meta_q;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_meta_q <= 2'h0;
      ext_sync_q <= 2'h0;
    end else begin
      ext_meta_q <= ext_meta_d;
      ext_sync_q <= ext_sync_d;
    end
  end

  // ----------------------------------------
  // Source lines in natural rank order
  // ----------------------------------------
  logic [NSRC-1:0] src_req;
  logic [7:0] vec_tab [NSRC];

  always_comb begin
    src_req = '0;
    src_req[FLIP_SRC_EXT0] = ext_sync_q[0];
    src_req[FLIP_SRC_TMR0] = timer_zero_overflow_in;
    src_req[FLIP_SRC_EXT1] = ext_sync_q[1];
    src_req[FLIP_SRC_TMR1] = timer_one_overflow_in;
    src_req[FLIP_SRC_PCA] = counter_array_in;
    src_req[FLIP_SRC_SER] = |serial_rx_tx_done_in;
    src_req[FLIP_SRC_TMR2] = timer_two_overflow_in;
    src_req[FLIP_SRC_CAN] = |can_event_in;
    src_req[FLIP_SRC_ADC] = adc_done_request_in;
    src_req[FLIP_SRC_CANSW] = can_sw_timer_in;
  end

  always_comb begin
    vec_tab[FLIP_SRC_EXT0] = `FLIP_VEC_EXT0;
    vec_tab[FLIP_SRC_TMR0] = `FLIP_VEC_TMR0;
    vec_tab[FLIP_SRC_EXT1] = `FLIP_VEC_EXT1;
    vec_tab[FLIP_SRC_TMR1] = `FLIP_VEC_TMR1;
    vec_tab[FLIP_SRC_PCA] = `FLIP_VEC_PCA;
    vec_tab[FLIP_SRC_SER] = `FLIP_VEC_SER;
    vec_tab[FLIP_SRC_TMR2] = `FLIP_VEC_TMR2;
    vec_tab[FLIP_SRC_CAN] = `FLIP_VEC_CAN;
    vec_tab[FLIP_SRC_ADC] = `FLIP_VEC_ADC;
    vec_tab[FLIP_SRC_CANSW] = `FLIP_VEC_CANSW;
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [15:0] prio_up_q;
  logic [15:0] prio_up_d;
  logic [15:0] prio_lo_q;
  logic [15:0] prio_lo_d;
  logic [15:0] en_q;
  logic [15:0] en_d;
  logic [15:0] sw_clr;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [NSRC-1:0] pend;
  logic [3:0] svc_q;
  logic [3:0] svc_d;

  always_comb begin
    prio_up_d = prio_up_q;
    prio_lo_d = prio_lo_q;
    en_d = en_q;
    sw_clr = 16'h0000;
    rdata_d = 8'h00;
    if (bus_in.wr) begin
      case (bus_in.addr)
        `FLIP_OFS_PRIO_UP0: prio_up_d[7:0] = bus_in.wdata;
        `FLIP_OFS_PRIO_UP1: prio_up_d[15:8] = bus_in.wdata;
        `FLIP_OFS_PRIO_LO0: prio_lo_d[7:0] = bus_in.wdata;
        `FLIP_OFS_PRIO_LO1: prio_lo_d[15:8] = bus_in.wdata;
        `FLIP_OFS_CLR0: sw_clr[7:0] = bus_in.wdata;
        `FLIP_OFS_CLR1: sw_clr[15:8] = bus_in.wdata;
        `FLIP_OFS_EN0: en_d[7:0] = bus_in.wdata;
        `FLIP_OFS_EN1: en_d[15:8] = bus_in.wdata;
        default: begin
        end
      endcase
    end
    // Only implemented bits are kept
    prio_up_d[15:NSRC] = '0;
    prio_lo_d[15:NSRC] = '0;
    en_d[15:NSRC] = '0;
    if (bus_in.rd) begin
      case (bus_in.addr)
        `FLIP_OFS_PRIO_UP0: rdata_d = prio_up_q[7:0];
        `FLIP_OFS_PRIO_UP1: rdata_d = prio_up_q[15:8];
        `FLIP_OFS_PRIO_LO0: rdata_d = prio_lo_q[7:0];
        `FLIP_OFS_PRIO_LO1: rdata_d = prio_lo_q[15:8];
        `FLIP_OFS_STAT0: rdata_d = pend[7:0];
        `FLIP_OFS_STAT1: rdata_d = {6'h00, pend[NSRC-1:8]};
        `FLIP_OFS_EN0: rdata_d = en_q[7:0];
        `FLIP_OFS_EN1: rdata_d = en_q[15:8];
        `FLIP_OFS_SERVICE: rdata_d = {4'h0, svc_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prio_up_q <= {2{`FLIP_RST_PRIO_UP}};
      prio_lo_q <= {2{`FLIP_RST_PRIO_LO}};
      en_q <= {2{`FLIP_RST_EN}};
      rdata_q <= 8'h00;
    end else begin
      prio_up_q <= prio_up_d;
      prio_lo_q <= prio_lo_d;
      en_q <= en_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata_out = rdata_q;

  // ----------------------------------------
  // Pending flags
  // ----------------------------------------
  flip_core_t core_q;
  flip_core_t core_d;
  logic [3:0] win_idx_q;
  logic [3:0] win_idx_d;
  logic take;

  // Core takes the vector only while it is offered
  assign take = core_ret_in.ack & core_q.req;

  // Ack retires only the source that won the standing offer;
  // a new edge on that source in the same cycle still wins
  logic [NSRC-1:0] hw_clr;

  always_comb begin
    hw_clr = '0;
    for (int k = 0; k < NSRC; k++) begin
      hw_clr[k] = take && (win_idx_q == 4'(k));
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_src
      flip_source_cell #(
        .EDGE_MODE(1'b1)
      ) u_cell (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .src_req_in(src_req[gi]),
        .clear_in(sw_clr[gi] | hw_clr[gi]),
        .pend_out(pend[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  logic [1:0] lvl [NSRC];
  logic found;
  logic [1:0] best_lvl;
  logic [3:0] best_idx;
  logic svc_act;
  logic [1:0] svc_lvl;
  logic preempt;

  always_comb begin
    found = 1'b0;
    best_lvl = 2'h0;
    best_idx = 4'h0;
    for (int i = 0; i < NSRC; i++) begin
      lvl[i] = {prio_up_q[i], prio_lo_q[i]};
      // Ascending rank scan with strict compare keeps lower rank on ties
      if (pend[i] && en_q[i] && (!found || lvl[i] > best_lvl)) begin
        found = 1'b1;
        best_lvl = lvl[i];
        best_idx = 4'(i);
      end
    end
  end

  // One bit per level is enough: a level can be in service only once,
  // since equal levels never preempt each other
  always_comb begin
    svc_act = |svc_q;
    svc_lvl = 2'h0;
    for (int l = 0; l < `FLIP_NUM_LVL; l++) begin
      if (svc_q[l]) begin
        svc_lvl = 2'(l);
      end
    end
    preempt = !svc_act || (best_lvl > svc_lvl);
  end

  // ----------------------------------------
  // Core request and service stack
  // ----------------------------------------
  always_comb begin
    core_d.req = found && preempt && !take;
    core_d.vector = vec_tab[best_idx];
    core_d.level = best_lvl;
    win_idx_d = best_idx;
    svc_d = svc_q;
    // Return retires the highest level in service
    if (core_ret_in.reti && svc_act) begin
      svc_d[svc_lvl] = 1'b0;
    end
    if (take) begin
      svc_d[core_q.level] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      core_q <= '0;
      win_idx_q <= 4'h0;
      svc_q <= 4'h0;
    end else begin
      core_q <= core_d;
      win_idx_q <= win_idx_d;
      svc_q <= svc_d;
    end
  end

  assign core_out = core_q;

  // ----------------------------------------
  // Interrupt line
  // ----------------------------------------
  logic irq_q;
  logic irq_d;

  // Level summary only; it ignores the service state, so it may stay
  // high while an offer is held back for a lower or equal level
  always_comb begin
    irq_d = |(pend & en_q[NSRC-1:0]);
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign irq_out = irq_q;

endmodule

// *** core/flip_regs.svh ***
`ifndef FLIP_REGS_SVH
`define FLIP_REGS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define FLIP_NUM_SRC 10
`define FLIP_NUM_LVL 4

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FLIP_OFS_PRIO_UP0 8'hB7
`define FLIP_OFS_PRIO_LO0 8'hB8
`define FLIP_OFS_PRIO_LO1 8'hB9
`define FLIP_OFS_PRIO_UP1 8'hBA
`define FLIP_OFS_STAT0 8'hC0
`define FLIP_OFS_STAT1 8'hC1
`define FLIP_OFS_CLR0 8'hC2
`define FLIP_OFS_CLR1 8'hC3
`define FLIP_OFS_EN0 8'hC4
`define FLIP_OFS_EN1 8'hC5
`define FLIP_OFS_SERVICE 8'hC6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FLIP_RST_PRIO_UP 8'h00
`define FLIP_RST_PRIO_LO 8'h00
`define FLIP_RST_EN 8'h00

// ----------------------------------------
// Vectors, in natural rank order
// ----------------------------------------
`define FLIP_VEC_EXT0 8'h03
`define FLIP_VEC_TMR0 8'h0B
`define FLIP_VEC_EXT1 8'h13
`define FLIP_VEC_TMR1 8'h1B
`define FLIP_VEC_PCA 8'h33
`define FLIP_VEC_SER 8'h23
`define FLIP_VEC_TMR2 8'h2B
`define FLIP_VEC_CAN 8'h3B
`define FLIP_VEC_ADC 8'h43
`define FLIP_VEC_CANSW 8'h4B

`endif

// *** core/flip_source_cell.sv ***
`timescale 1ns/1ps
// Sticky pending flag of one source; set wins over clear
module flip_source_cell #(
  parameter bit EDGE_MODE = 1'b1
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic src_req_in,
  input wire logic clear_in,
  output logic pend_out
);

  logic req_prev_q;
  logic req_prev_d;
  logic pend_q;
  logic pend_d;
  logic set_w;

  always_comb begin
    set_w = EDGE_MODE ? (src_req_in & ~req_prev_q) : src_req_in;
    req_prev_d = src_req_in;
    pend_d = pend_q;
    if (clear_in) begin
      pend_d = 1'b0;
    end
    if (set_w) begin
      pend_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_prev_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      req_prev_q <= req_prev_d;
      pend_q <= pend_d;
    end
  end

  assign pend_out = pend_q;

endmodule

// *** tb/flip_core_model.sv ***
`timescale 1ns/1ps
// ---
// Core side: takes an offer after lag_in cycles
// ---
module flip_core_model (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire flip_pkg::flip_core_t core_in,
  input wire logic [3:0] lag_in,
  input wire logic ret_go_in,
  output flip_pkg::flip_core_ret_t ret_out,
  output logic [7:0] took_out,
  output logic [1:0] lvl_out
);
  import flip_pkg::*;
  logic [3:0] cnt_q;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 4'h0;
      ret_out <= '0;
      took_out <= 8'h00;
      lvl_out <= 2'h0;
    end else begin
      ret_out.reti <= ret_go_in;
      ret_out.ack <= 1'b0;
      cnt_q <= 4'h0;
      if (ret_out.ack) begin
        took_out <= core_in.vector;
        lvl_out <= core_in.level;
      end else if (core_in.req && cnt_q >= lag_in) begin
        // Ack only while the offer stands, never in the gap cycle
        ret_out.ack <= 1'b1;
      end else if (core_in.req) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

// *** tb/flip_prioritizer_props.sv ***
`timescale 1ns/1ps
// ---
// Port checker
// ---
module flip_prioritizer_props (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire flip_pkg::flip_bus_t bus_in,
  input wire flip_pkg::flip_core_t core_out,
  input wire flip_pkg::flip_core_ret_t core_ret_in,
  input wire logic [7:0] rdata_out,
  input wire logic irq_out
);
  import flip_pkg::*;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_rdata_idle: assert property (!$past(bus_in.rd) |-> rdata_out == 8'h00)
    else $error("read data outside its slot");
  a_zero_reads: assert property (bus_in.rd && bus_in.addr inside {8'hC2, 8'hC3, 8'h00}
    |=> rdata_out == 8'h00)
    else $error("clear or unmapped read not zero");
  a_reset_quiet: assert property ($rose(rst_n_in) |-> !core_out.req && !irq_out)
    else $error("outputs active after reset");
  a_req_holds: assert property (core_out.req && !core_ret_in.ack |=> core_out.req)
    else $error("offer withdrawn before ack");
  a_ack_drops: assert property (core_out.req && core_ret_in.ack |=> !core_out.req)
    else $error("offer still up after ack");
  a_offer_stable: assert property (core_out.req && !core_ret_in.ack
    |=> $stable(core_out.vector) && $stable(core_out.level))
    else $error("offer changed while standing");
  a_vector_legal: assert property (core_out.req |-> core_out.vector inside {8'h03, 8'h0B,
    8'h13, 8'h1B, 8'h23, 8'h2B, 8'h33, 8'h3B, 8'h43, 8'h4B})
    else $error("offer with unknown vector");
  a_req_has_irq: assert property (core_out.req |-> irq_out)
    else $error("offer without enabled pending source");
endmodule

// *** tb/test_flip_prioritizer.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module test_flip_prioritizer;
  import flip_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  flip_bus_t bus = '0;
  flip_core_t core;
  flip_core_ret_t ret;
  logic [7:0] rdata;
  logic [7:0] took;
  logic [1:0] tlvl;
  logic irq;
  logic ret_go = 1'b0;
  logic [3:0] lag = 4'h1;
  logic [9:0] src = '0;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] regs [11] = '{8'hB7, 8'hB8, 8'hB9, 8'hBA, 8'hC0, 8'hC1, 8'hC2, 8'hC3,
    8'hC4, 8'hC5, 8'hC6};
  logic [7:0] vecs [10] = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h33, 8'h23, 8'h2B, 8'h3B,
    8'h43, 8'h4B};

  always #2 sys_clk_in = ~sys_clk_in;

  flip_prioritizer DUT (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .bus_in(bus),
    .core_out(core),
    .core_ret_in(ret),
    .rdata_out(rdata),
    .irq_out(irq),
    .ext_request_zero_in(src[0]),
    .ext_request_one_in(src[2]),
    .timer_zero_overflow_in(src[1]),
    .timer_one_overflow_in(src[3]),
    .timer_two_overflow_in(src[6]),
    .serial_rx_tx_done_in({src[5], 1'b0}),
    .counter_array_in(src[4]),
    .can_event_in({src[7], 2'b00}),
    .adc_done_request_in(src[8]),
    .can_sw_timer_in(src[9])
  );

  flip_core_model core_side (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .core_in(core),
    .lag_in(lag),
    .ret_go_in(ret_go),
    .ret_out(ret),
    .took_out(took),
    .lvl_out(tlvl)
  );

  // ---
  // Bus and core helpers, entered just after a rising edge
  // ---
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk_in);
    bus <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk_in);
    bus <= '0;
    #1 `CHK(rdata, e)
    @(posedge sys_clk_in);
  endtask

  task automatic look(input logic r, input logic i);
    #1 `CHK(core.req, r)
    `CHK(irq, i)
    @(posedge sys_clk_in);
  endtask

  task automatic serve(input logic [7:0] v, input logic [1:0] l);
    @(posedge sys_clk_in iff ret.ack);
    #1 `CHK(took, v)
    `CHK(tlvl, l)
    @(posedge sys_clk_in);
  endtask

  task automatic reti;
    ret_go <= 1'b1;
    @(posedge sys_clk_in);
    ret_go <= 1'b0;
    tick(2);
  endtask

  // ---
  // Scenarios
  // ---
  task automatic t_reset;
    foreach (regs[i]) rd(regs[i], 8'h00);
    rd(8'h00, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_rank;
    wr(8'hC4, 8'hFF);
    wr(8'hC5, 8'h03);
    // Pins first, so their synchroniser delay cannot reorder the ranks
    src <= 10'h005;
    tick(3);
    src <= 10'h3FF;
    for (int i = 0; i < 10; i++) begin
      serve(vecs[i], 2'h0);
      reti;
    end
    src <= '0;
    $display("test rank done");
  endtask

  task automatic t_levels;
    wr(8'hB7, 8'h04);
    wr(8'hB8, 8'h02);
    wr(8'hB9, 8'h01);
    wr(8'hBA, 8'h01);
    rd(8'hB7, 8'h04);
    src <= 10'h001;
    serve(8'h03, 2'h0);
    src <= 10'h003;
    serve(8'h0B, 2'h1);
    src <= 10'h007;
    serve(8'h13, 2'h2);
    src <= 10'h017;
    tick(10);
    look(1'b0, 1'b1);
    src <= 10'h117;
    serve(8'h43, 2'h3);
    repeat (3) reti;
    look(1'b0, 1'b1);
    reti;
    serve(8'h33, 2'h0);
    reti;
    src <= '0;
    $display("test levels done");
  endtask

  task automatic t_irq;
    wr(8'hC4, 8'h00);
    src <= 10'h008;
    tick(3);
    rd(8'hC0, 8'h08);
    look(1'b0, 1'b0);
    wr(8'hC2, 8'h08);
    rd(8'hC0, 8'h00);
    src <= '0;
    lag <= 4'h8;
    tick(1);
    src <= 10'h008;
    tick(3);
    wr(8'hC4, 8'hFF);
    tick(2);
    look(1'b1, 1'b1);
    serve(8'h1B, 2'h0);
    tick(1);
    look(1'b0, 1'b0);
    reti;
    $display("test irq done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      report_and_stop;
    end
  end

  initial begin
    tick(3);
    rst_n_in <= 1'b1;
    t_reset;
    t_rank;
    t_levels;
    t_irq;
    report_and_stop;
  end
endmodule

bind flip_prioritizer flip_prioritizer_props u_props (.sys_clk_in, .rst_n_in, .bus_in,
  .core_out, .core_ret_in, .rdata_out, .irq_out);
